// ===== hw/dbw_regs.vh
`ifndef DBW_REGS_VH
`define DBW_REGS_VH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define DBW_CAUSE_IDX 8'h15
`define DBW_INFO_IDX 8'h16
`define DBW_STOP_IDX 8'h18
`define DBW_SCRATCH_IDX 8'h20
`define DBW_IBA_IDX 8'h30
`define DBW_IBC_IDX 8'h40
`define DBW_DWA_IDX 8'h50
`define DBW_DWB_IDX 8'h60
`define DBW_DWC_IDX 8'h70
`define DBW_RWM_IDX 8'h80
`define DBW_RWV_IDX 8'h90
`define DBW_RWC_IDX 8'h9C
`define DBW_MODE_IDX 8'hA0
// ----------------------------------------
// Fields
// ----------------------------------------
`define DBW_CTL_EN 0
`define DBW_CTL_COND 1
`define DBW_CTL_LOAD 2
`define DBW_CTL_THR_LO 16
`define DBW_CTL_THR_HI 23
`define DBW_CAUSE_LO 0
`define DBW_CAUSE_HI 2
`define DBW_THR_LO 8
`define DBW_THR_HI 15
`define DBW_NUM_LO 16
`define DBW_NUM_HI 17
`define DBW_IBC_MASK 32'h00FF0003
`define DBW_DWC_MASK 32'h00FF0007
`define DBW_RWC_MASK 32'h00FF0003
// ----------------------------------------
// Cause codes and reset values
// ----------------------------------------
`define DBW_CAUSE_HOST 3'h1
`define DBW_CAUSE_DEBUG_CALL_INSTRUCTION 3'h2
`define DBW_CAUSE_IBRK 3'h3
`define DBW_CAUSE_DWATCH 3'h4
`define DBW_CAUSE_RWATCH 3'h5
`define DBW_RST_CTL 32'h00000000
`define DBW_RST_WORD 32'h00000000
`endif

// ===== hw/dbw_unit.v
// Summary of operation
// RULE1: Cause code: 1 host, 2 debug call, 3 instr, 4 data, 5 resource.
// RULE2: Two-bit trigger index, zero for host request or debug call.
// RULE3: Several triggers at once report the lowest index.
// RULE4: Eight-bit thread number recorded, zero for host request.
// RULE5: Info word takes data address or resource identifier on hit.
// RULE6: Stop mask holds set threads when out of debug mode.
// RULE7: Eight scratch words, shared with the tile configuration port.
// RULE8: Four instruction breakpoints each with own address raise interrupt.
// RULE9: Condition bit 0 means PC equal, 1 means PC different.
// RULE10: Per-thread enable field in every control, controls reset zero.
// RULE11: Control bit 0 enables each trigger, resets disabled.
// RULE12: Four data watchpoints with address A and address B.
// RULE13: Data watchpoints fire on loads only when control bit 2 set.
// RULE14: Data conditions joined by AND if bit 1 clear, OR if set.
// RULE15: Four resource watchpoints with mask and value registers.
// RULE16: Resource bit 1 picks condition A or condition B.
// RULE17: Condition A masked id equals value, B masked id differs.
// RULE18: Data condition A address at least A, B address at most B.
// RULE19: Software uses status set and get instructions for this group.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "dbw_regs.vh"
module dbw_unit #(
    parameter NTHR = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Register port
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // Tile configuration scratch port
    input wire [2:0] i_cfg_addr,
    input wire [31:0] i_cfg_wdata,
    input wire i_cfg_wr,
    output reg [31:0] o_cfg_rdata,
    // Pipeline instruction stream
    input wire i_pc_valid,
    input wire [31:0] i_pc,
    input wire [7:0] i_pc_thread,
    input wire i_debug_call_instruction,
    // Pipeline memory stream
    input wire i_mem_valid,
    input wire i_mem_load,
    input wire [31:0] i_mem_addr,
    input wire [7:0] i_mem_thread,
    // Pipeline resource stream
    input wire i_res_valid,
    input wire [31:0] i_res_id,
    input wire [7:0] i_res_thread,
    // Host request and debug state
    input wire i_host_req,
    input wire i_debug_exit,
    // Outputs
    output wire o_debug_irq,
    output reg o_debug_mode,
    output wire [NTHR-1:0] o_thread_stop
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [31:0] iba_reg [0:3];
    reg [31:0] ibc_reg [0:3];
    reg [31:0] dwa_reg [0:3];
    reg [31:0] dwb_reg [0:3];
    reg [31:0] dwc_reg [0:3];
    reg [31:0] rwm_reg [0:3];
    reg [31:0] rwv_reg [0:3];
    reg [31:0] rwc_reg [0:3];
    reg [31:0] scratch_reg [0:7];
    reg [2:0] cause_reg;
    reg [7:0] thr_reg;
    reg [1:0] num_reg;
    reg [31:0] info_reg;
    reg [7:0] stop_reg;
    reg [31:0] rdata_next;
    reg [3:0] ib_hit;
    reg [3:0] dw_hit;
    reg [3:0] rw_hit;
    reg dw_ca;
    reg dw_cb;
    reg rw_eq;
    integer k;
    integer j;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function thr_en;
        input [31:0] ctl;
        input [7:0] thr;
        begin
            // Thread enable
            thr_en = (thr < 8'h08) ? ctl[`DBW_CTL_THR_LO + thr[2:0]] : 1'b0;
        end
    endfunction

    function [1:0] low_idx;
        input [3:0] hits;
        begin
            // Lowest index
            if (hits[0]) begin
                low_idx = 2'h0;
            end else if (hits[1]) begin
                low_idx = 2'h1;
            end else if (hits[2]) begin
                low_idx = 2'h2;
            end else begin
                low_idx = 2'h3;
            end
        end
    endfunction

    function blk4;
        input [7:0] addr;
        input [7:0] base;
        begin
            // Four-word window
            blk4 = (addr[7:2] == base[7:2]);
        end
    endfunction

    function blk8;
        input [7:0] addr;
        input [7:0] base;
        begin
            // Eight-word window
            blk8 = (addr[7:3] == base[7:3]);
        end
    endfunction

    // ----------------------------------------
    // Trigger compare
    // ----------------------------------------
    always @* begin
        ib_hit = 4'h0;
        dw_hit = 4'h0;
        rw_hit = 4'h0;
        dw_ca = 1'b0;
        dw_cb = 1'b0;
        rw_eq = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            // RULE8: RULE9: RULE10: RULE11: Instruction match
            ib_hit[k] = i_pc_valid && ibc_reg[k][`DBW_CTL_EN] && thr_en(ibc_reg[k], i_pc_thread) &&
                ((i_pc == iba_reg[k]) ^ ibc_reg[k][`DBW_CTL_COND]);
            // RULE18: Address bounds
            dw_ca = i_mem_addr >= dwa_reg[k];
            dw_cb = i_mem_addr <= dwb_reg[k];
            // RULE12: RULE13: RULE14: Data match
            dw_hit[k] = i_mem_valid && i_mem_load && dwc_reg[k][`DBW_CTL_LOAD] && dwc_reg[k][`DBW_CTL_EN] &&
                thr_en(dwc_reg[k], i_mem_thread) &&
                (dwc_reg[k][`DBW_CTL_COND] ? (dw_ca | dw_cb) : (dw_ca & dw_cb));
            // RULE17: Masked compare
            rw_eq = (i_res_id & rwm_reg[k]) == (rwv_reg[k] & rwm_reg[k]);
            // RULE15: RULE16: Resource match
            rw_hit[k] = i_res_valid && rwc_reg[k][`DBW_CTL_EN] && thr_en(rwc_reg[k], i_res_thread) &&
                (rwc_reg[k][`DBW_CTL_COND] ? !rw_eq : rw_eq);
        end
    end

    wire any_trig = !o_debug_mode && (i_host_req || i_debug_call_instruction || (|ib_hit) ||
        (|dw_hit) || (|rw_hit));
    assign o_debug_irq = any_trig;
    // RULE6: Thread stop
    assign o_thread_stop = o_debug_mode ? {NTHR{1'b0}} : stop_reg[NTHR-1:0];

    // ----------------------------------------
    // Registers and capture
    // ----------------------------------------
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (j = 0; j < 4; j = j + 1) begin
                iba_reg[j] <= `DBW_RST_WORD;
                ibc_reg[j] <= `DBW_RST_CTL;
                dwa_reg[j] <= `DBW_RST_WORD;
                dwb_reg[j] <= `DBW_RST_WORD;
                dwc_reg[j] <= `DBW_RST_CTL;
                rwm_reg[j] <= `DBW_RST_WORD;
                rwv_reg[j] <= `DBW_RST_WORD;
                rwc_reg[j] <= `DBW_RST_CTL;
            end
            for (j = 0; j < 8; j = j + 1) begin
                scratch_reg[j] <= `DBW_RST_WORD;
            end
            cause_reg <= 3'h0;
            thr_reg <= 8'h00;
            num_reg <= 2'h0;
            info_reg <= `DBW_RST_WORD;
            stop_reg <= 8'h00;
            o_debug_mode <= 1'b0;
        end else begin
            if (i_wr) begin
                case (i_addr)
                    // Software write of cause fields
                    `DBW_CAUSE_IDX: begin
                        cause_reg <= i_wdata[`DBW_CAUSE_HI:`DBW_CAUSE_LO];
                        thr_reg <= i_wdata[`DBW_THR_HI:`DBW_THR_LO];
                        num_reg <= i_wdata[`DBW_NUM_HI:`DBW_NUM_LO];
                    end
                    `DBW_INFO_IDX: begin
                        info_reg <= i_wdata;
                    end
                    // RULE6: Stop mask write
                    `DBW_STOP_IDX: begin
                        stop_reg <= i_wdata[7:0];
                    end
                    default: begin
                        // RULE7: Scratch write
                        if (blk8(i_addr, `DBW_SCRATCH_IDX)) begin
                            scratch_reg[i_addr[2:0]] <= i_wdata;
                        end
                        // RULE8: Breakpoint address
                        if (blk4(i_addr, `DBW_IBA_IDX)) begin
                            iba_reg[i_addr[1:0]] <= i_wdata;
                        end
                        // RULE10: RULE11: Breakpoint control
                        if (blk4(i_addr, `DBW_IBC_IDX)) begin
                            ibc_reg[i_addr[1:0]] <= i_wdata & `DBW_IBC_MASK;
                        end
                        // RULE12: Data addresses
                        if (blk4(i_addr, `DBW_DWA_IDX)) begin
                            dwa_reg[i_addr[1:0]] <= i_wdata;
                        end
                        if (blk4(i_addr, `DBW_DWB_IDX)) begin
                            dwb_reg[i_addr[1:0]] <= i_wdata;
                        end
                        // RULE13: RULE14: Data control
                        if (blk4(i_addr, `DBW_DWC_IDX)) begin
                            dwc_reg[i_addr[1:0]] <= i_wdata & `DBW_DWC_MASK;
                        end
                        // RULE15: Resource mask value
                        if (blk4(i_addr, `DBW_RWM_IDX)) begin
                            rwm_reg[i_addr[1:0]] <= i_wdata;
                        end
                        if (blk4(i_addr, `DBW_RWV_IDX)) begin
                            rwv_reg[i_addr[1:0]] <= i_wdata;
                        end
                        // RULE16: Resource control
                        if (blk4(i_addr, `DBW_RWC_IDX)) begin
                            rwc_reg[i_addr[1:0]] <= i_wdata & `DBW_RWC_MASK;
                        end
                    end
                endcase
            end
            // RULE7: Shared scratch
            if (i_cfg_wr && !(i_wr && blk8(i_addr, `DBW_SCRATCH_IDX) && i_addr[2:0] == i_cfg_addr)) begin
                scratch_reg[i_cfg_addr] <= i_cfg_wdata;
            end
            // RULE6: Return from debug
            if (i_debug_exit) begin
                o_debug_mode <= 1'b0;
            end
            // Capture wins over software write
            if (any_trig) begin
                o_debug_mode <= 1'b1;
                // RULE1: RULE2: RULE4: Host and call
                if (i_host_req) begin
                    cause_reg <= `DBW_CAUSE_HOST;
                    thr_reg <= 8'h00;
                    num_reg <= 2'h0;
                end else if (i_debug_call_instruction) begin
                    cause_reg <= `DBW_CAUSE_DEBUG_CALL_INSTRUCTION;
                    thr_reg <= i_pc_thread;
                    num_reg <= 2'h0;
                end else if (|ib_hit) begin
                    // RULE3: Lowest index
                    cause_reg <= `DBW_CAUSE_IBRK;
                    thr_reg <= i_pc_thread;
                    num_reg <= low_idx(ib_hit);
                end else if (|dw_hit) begin
                    // RULE5: Data address
                    cause_reg <= `DBW_CAUSE_DWATCH;
                    thr_reg <= i_mem_thread;
                    num_reg <= low_idx(dw_hit);
                    info_reg <= i_mem_addr;
                end else begin
                    // RULE5: Resource id
                    cause_reg <= `DBW_CAUSE_RWATCH;
                    thr_reg <= i_res_thread;
                    num_reg <= low_idx(rw_hit);
                    info_reg <= i_res_id;
                end
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        case (i_addr)
            `DBW_CAUSE_IDX: rdata_next = {14'h0, num_reg, thr_reg, 5'h00, cause_reg};
            `DBW_INFO_IDX: rdata_next = info_reg;
            `DBW_STOP_IDX: rdata_next = {24'h000000, stop_reg};
            `DBW_MODE_IDX: rdata_next = {31'h0, o_debug_mode};
            default: begin
                // RULE7: Scratch readback
                if (blk8(i_addr, `DBW_SCRATCH_IDX)) begin
                    rdata_next = scratch_reg[i_addr[2:0]];
                end
                // RULE8: Breakpoint readback
                if (blk4(i_addr, `DBW_IBA_IDX)) begin
                    rdata_next = iba_reg[i_addr[1:0]];
                end
                // RULE10: Control readback
                if (blk4(i_addr, `DBW_IBC_IDX)) begin
                    rdata_next = ibc_reg[i_addr[1:0]];
                end
                // RULE12: Watch readback
                if (blk4(i_addr, `DBW_DWA_IDX)) begin
                    rdata_next = dwa_reg[i_addr[1:0]];
                end
                if (blk4(i_addr, `DBW_DWB_IDX)) begin
                    rdata_next = dwb_reg[i_addr[1:0]];
                end
                if (blk4(i_addr, `DBW_DWC_IDX)) begin
                    rdata_next = dwc_reg[i_addr[1:0]];
                end
                if (blk4(i_addr, `DBW_RWM_IDX)) begin
                    rdata_next = rwm_reg[i_addr[1:0]];
                end
                if (blk4(i_addr, `DBW_RWV_IDX)) begin
                    rdata_next = rwv_reg[i_addr[1:0]];
                end
                if (blk4(i_addr, `DBW_RWC_IDX)) begin
                    rdata_next = rwc_reg[i_addr[1:0]];
                end
            end
        endcase
    end

    // Registered read data
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h00000000;
            o_cfg_rdata <= 32'h00000000;
        end else begin
            o_rdata <= i_rd ? rdata_next : 32'h00000000;
            o_cfg_rdata <= scratch_reg[i_cfg_addr];
        end
    end
endmodule

// ===== verif/dbw_unit_assertions.sv
`timescale 1ns/10ps
module dbw_unit_chk #(
    parameter NTHR = 8
) (
    // Clock and reset
    input logic i_clk,
    input logic i_resetn,
    // Register and scratch ports
    input logic [7:0] i_addr,
    input logic [31:0] i_wdata,
    input logic i_wr,
    input logic i_rd,
    input logic [31:0] o_rdata,
    input logic [2:0] i_cfg_addr,
    input logic i_cfg_wr,
    input logic [31:0] o_cfg_rdata,
    // Trigger sources and outputs
    input logic i_pc_valid,
    input logic i_debug_call_instruction,
    input logic i_mem_valid,
    input logic i_res_valid,
    input logic i_host_req,
    input logic i_debug_exit,
    input logic o_debug_irq,
    input logic o_debug_mode,
    input logic [NTHR-1:0] o_thread_stop
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    chk_irq_enters_mode: assert property (o_debug_irq |=> o_debug_mode)
        else $error("irq did not enter debug mode");
    chk_irq_quiet_mode: assert property (o_debug_mode |-> !o_debug_irq)
        else $error("irq raised while in debug mode");
    chk_host_raises_irq: assert property ((i_host_req && !o_debug_mode) |-> o_debug_irq)
        else $error("host request gave no irq");
    chk_idle_no_irq: assert property ((!i_pc_valid && !i_mem_valid && !i_res_valid && !i_host_req
        && !i_debug_call_instruction) |-> !o_debug_irq) else $error("irq without any source");
    chk_stop_in_mode: assert property (o_debug_mode |-> o_thread_stop == '0)
        else $error("threads stopped inside debug mode");
    chk_exit_mode: assert property ((o_debug_mode && i_debug_exit && !o_debug_irq) |=> !o_debug_mode)
        else $error("debug mode kept after exit");
    chk_mode_holds: assert property ((o_debug_mode && !i_debug_exit) |=> o_debug_mode)
        else $error("debug mode dropped without exit");
    chk_scratch_readback: assert property ((i_wr && i_addr == 8'h20) ##1 !i_wr ##1
        (i_rd && i_addr == 8'h20) |=> o_rdata == $past(i_wdata, 3)) else $error("scratch readback wrong");
    chk_scratch_shared: assert property ((i_wr && i_addr == 8'h21) ##1 (i_cfg_addr == 3'h1 && !i_cfg_wr)
        |=> o_cfg_rdata == $past(i_wdata, 2)) else $error("config port scratch differs");
endmodule
bind dbw_unit dbw_unit_chk #(.NTHR(NTHR)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cfg_addr(i_cfg_addr),
    .i_cfg_wr(i_cfg_wr), .o_cfg_rdata(o_cfg_rdata), .i_pc_valid(i_pc_valid),
    .i_debug_call_instruction(i_debug_call_instruction), .i_mem_valid(i_mem_valid),
    .i_res_valid(i_res_valid), .i_host_req(i_host_req), .i_debug_exit(i_debug_exit),
    .o_debug_irq(o_debug_irq), .o_debug_mode(o_debug_mode), .o_thread_stop(o_thread_stop));

// ===== verif/dbw_pipe_model.sv
`timescale 1ns/10ps
module dbw_pipe_model (
    input logic i_clk,
    output logic o_pc_valid, o_debug_call_instruction, o_mem_valid, o_mem_load, o_res_valid,
    output logic [31:0] o_pc, o_mem_addr, o_res_id,
    output logic [7:0] o_pc_thread, o_mem_thread, o_res_thread
);
    // ----------------------------------------
    // Issue one operation, then release the lines
    // ----------------------------------------
    initial begin
        {o_pc_valid, o_debug_call_instruction, o_mem_valid, o_mem_load, o_res_valid} = 5'h00;
        {o_pc, o_mem_addr, o_res_id} = {96{1'b1}};
        {o_pc_thread, o_mem_thread, o_res_thread} = 24'hFFFFFF;
    end
    task automatic issue(input int kind, input logic [31:0] val, input logic [7:0] thr, input logic flag);
        @(posedge i_clk);
        o_pc_valid <= kind == 0;
        o_mem_valid <= kind == 1;
        o_res_valid <= kind == 2;
        {o_pc, o_mem_addr, o_res_id} <= {3{val}};
        {o_pc_thread, o_mem_thread, o_res_thread} <= {3{thr}};
        o_debug_call_instruction <= flag && kind == 0;
        o_mem_load <= flag;
        @(posedge i_clk);
        {o_pc_valid, o_debug_call_instruction, o_mem_valid, o_res_valid} <= 4'h0;
        o_mem_load <= ~flag;
        {o_pc, o_mem_addr, o_res_id} <= {3{~val}};
        {o_pc_thread, o_mem_thread, o_res_thread} <= {3{~thr}};
    endtask
endmodule

// ===== verif/tb_dbw_unit.sv
`timescale 1ns/10ps
module tb_dbw_unit;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h00000000;
    logic [31:0] i_cfg_wdata = 32'h00000000;
    logic [2:0] i_cfg_addr = 3'h1;
    logic i_wr = 1'b0, i_rd = 1'b0, i_cfg_wr = 1'b0, i_host_req = 1'b0, i_debug_exit = 1'b0;
    logic i_pc_valid, i_debug_call_instruction, i_mem_valid, i_mem_load, i_res_valid, o_debug_irq, o_debug_mode;
    logic [31:0] i_pc, i_mem_addr, i_res_id, o_rdata, o_cfg_rdata;
    logic [7:0] i_pc_thread, i_mem_thread, i_res_thread, o_thread_stop;
    int err_total = 0;
    int cmp_count = 0;
    always #5 i_clk = ~i_clk;
    dbw_unit #(.NTHR(8)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
        .i_cfg_wr(i_cfg_wr), .o_cfg_rdata(o_cfg_rdata), .i_pc_valid(i_pc_valid), .i_pc(i_pc),
        .i_pc_thread(i_pc_thread), .i_debug_call_instruction(i_debug_call_instruction),
        .i_mem_valid(i_mem_valid), .i_mem_load(i_mem_load), .i_mem_addr(i_mem_addr), .i_mem_thread(i_mem_thread),
        .i_res_valid(i_res_valid), .i_res_id(i_res_id), .i_res_thread(i_res_thread), .i_host_req(i_host_req),
        .i_debug_exit(i_debug_exit), .o_debug_irq(o_debug_irq), .o_debug_mode(o_debug_mode),
        .o_thread_stop(o_thread_stop));
    dbw_pipe_model pipe (.i_clk(i_clk), .o_pc_valid(i_pc_valid), .o_debug_call_instruction(i_debug_call_instruction),
        .o_mem_valid(i_mem_valid), .o_mem_load(i_mem_load), .o_res_valid(i_res_valid), .o_pc(i_pc),
        .o_mem_addr(i_mem_addr), .o_res_id(i_res_id), .o_pc_thread(i_pc_thread), .o_mem_thread(i_mem_thread),
        .o_res_thread(i_res_thread));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic end_sim;
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check("rdata", o_rdata, exp);
    endtask
    task automatic look(input logic hit, input logic [31:0] cause, input logic [31:0] info);
        #1 check("mode", {31'h0, o_debug_mode}, {31'h0, hit});
        if (hit) begin
            rd(8'h15, cause);
            rd(8'h16, info);
            check("stop", {24'h0, o_thread_stop}, 32'h00000000);
            @(posedge i_clk);
            i_debug_exit <= 1'b1;
            @(posedge i_clk);
            i_debug_exit <= 1'b0;
        end
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd(8'h40 + 8'(k), 32'h00000000);
            rd(8'h70 + 8'(k), 32'h00000000);
            rd(8'h9C + 8'(k), 32'h00000000);
        end
        rd(8'h01, 32'h00000000);
        wr(8'h20, 32'hA5A50001);
        rd(8'h20, 32'hA5A50001);
        wr(8'h21, 32'h5A5A0002);
        @(posedge i_clk);
        i_cfg_addr <= 3'h5;
        i_cfg_wdata <= 32'h0000C0DE;
        i_cfg_wr <= 1'b1;
        @(posedge i_clk);
        i_cfg_wr <= 1'b0;
        i_cfg_addr <= 3'h1;
        rd(8'h25, 32'h0000C0DE);
        check("cfg", o_cfg_rdata, 32'h5A5A0002);
        wr(8'h31, 32'h00000100);
        wr(8'h32, 32'h00000100);
        pipe.issue(0, 32'h00000100, 8'h02, 1'b0);
        look(1'b0, 32'h0, 32'h0);
        wr(8'h41, 32'h00040001);
        wr(8'h42, 32'h00040001);
        pipe.issue(0, 32'h00000100, 8'h02, 1'b0);
        look(1'b1, 32'h00010203, 32'h0);
        pipe.issue(0, 32'h00000100, 8'h03, 1'b0);
        look(1'b0, 32'h0, 32'h0);
        wr(8'h42, 32'h00000000);
        wr(8'h41, 32'h00040003);
        pipe.issue(0, 32'h00000100, 8'h02, 1'b0);
        look(1'b0, 32'h0, 32'h0);
        pipe.issue(0, 32'h00000104, 8'h02, 1'b0);
        look(1'b1, 32'h00010203, 32'h0);
        wr(8'h41, 32'h00000000);
        wr(8'h50, 32'h00001000);
        wr(8'h60, 32'h00001FFF);
        wr(8'h70, 32'h00040005);
        pipe.issue(1, 32'h00002000, 8'h02, 1'b1);
        look(1'b0, 32'h0, 32'h0);
        pipe.issue(1, 32'h00001800, 8'h02, 1'b0);
        look(1'b0, 32'h0, 32'h0);
        pipe.issue(1, 32'h00001800, 8'h02, 1'b1);
        look(1'b1, 32'h00000204, 32'h00001800);
        wr(8'h70, 32'h00040007);
        pipe.issue(1, 32'h00002000, 8'h02, 1'b1);
        look(1'b1, 32'h00000204, 32'h00002000);
        wr(8'h70, 32'h00000000);
        wr(8'h83, 32'hFFFF0000);
        wr(8'h93, 32'h00AB0000);
        wr(8'h9F, 32'h00040001);
        pipe.issue(2, 32'h00AB1234, 8'h02, 1'b0);
        look(1'b1, 32'h00030205, 32'h00AB1234);
        wr(8'h9F, 32'h00040003);
        pipe.issue(2, 32'h00AB9999, 8'h02, 1'b0);
        look(1'b0, 32'h0, 32'h0);
        pipe.issue(2, 32'h00CD0000, 8'h02, 1'b0);
        look(1'b1, 32'h00030205, 32'h00CD0000);
        wr(8'h9F, 32'h00000000);
        pipe.issue(0, 32'h00000300, 8'h05, 1'b1);
        look(1'b1, 32'h00000502, 32'h00CD0000);
        wr(8'h18, 32'hFFFFFF24);
        rd(8'h18, 32'h00000024);
        check("stop", {24'h0, o_thread_stop}, 32'h00000024);
        @(posedge i_clk);
        i_host_req <= 1'b1;
        #1 check("irq", {31'h0, o_debug_irq}, 32'h00000001);
        @(posedge i_clk);
        i_host_req <= 1'b0;
        look(1'b1, 32'h00000001, 32'h00CD0000);
        #1 check("stop", {24'h0, o_thread_stop}, 32'h00000024);
        end_sim();
    end
endmodule
